// ===== sim/pmtr_prog_model.sv
// serial programmer model driving the programming link
// assumes frame of cmd, addr, data msb first, one extra edge commits
`default_nettype none
module pmtr_prog_model (
  output var logic sck,
  output var logic sd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // frame sender, clock stands low outside frames
  initial sck = 1'b0;
  initial sd = 1'b0;
  task automatic send(input logic [1:0] c, input logic [10:0] a, input logic [14:0] d);
    logic [27:0] f;
    f = {c, a, d};
    for (int i = 0; i < 29; i++)
    begin
      sd = (i < 28) ? f[27-i] : ~f[0];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    // released line, no pull: inverse of last bit
    sd = ~sd;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_program_memory_table_read.sv
// testbench for the program memory table read unit
// assumes link writes land well within ten cycles of the commit edge
`default_nettype none
module tb_program_memory_table_read;
  timeunit 1ns;
  timeprecision 1ns;
  import pmtr_pkg::*;
  logic        sys_clk, resetn, emul, fetch_en, tab_rd, last_pg;
  logic [1:0]  variant;
  logic [10:0] pc, fetch_addr;
  logic [14:0] instr_word;
  logic [7:0]  table_ptr, operand_addr, dm_addr, dm_wdata, table_high_byte;
  logic        dm_we, core_stall, alt_func_en, sck, sd, p_o, p_oe, d_o, d_oe;
  wire         p_pin = p_oe ? p_o : sd;
  wire         d_pin = d_oe ? d_o : sd;
  int          failures = 0;
  int          checked = 0;
  always #2 sys_clk = ~sys_clk;
  pmtr_prog_model u_prog (.sck(sck), .sd(sd));
  pmtr_top dut (
    .sys_clk(sys_clk), .resetn(resetn), .variant(variant), .emulation_chip(emul),
    .fetch_en(fetch_en), .pc(pc), .fetch_addr(fetch_addr), .instr_word(instr_word),
    .tab_rd(tab_rd), .last_page_table_read(last_pg), .table_ptr(table_ptr),
    .operand_addr(operand_addr), .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .table_high_byte(table_high_byte), .core_stall(core_stall), .alt_func_en(alt_func_en),
    .prog_serial_clock_pin(sck), .prog_serial_data_pin_i(p_pin),
    .prog_serial_data_pin_o(p_o), .prog_serial_data_pin_oe(p_oe),
    .debug_clock_pin(sck), .debug_data_addr_pin_i(d_pin),
    .debug_data_addr_pin_o(d_o), .debug_data_addr_pin_oe(d_oe));
  // ==========================================================
  // compare and verdict
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // table read, request held into the stall to be refused
  task automatic tread(input logic [1:0] v, input logic lp, input logic [10:0] p,
                       input logic [15:0] lo, input logic [15:0] hi);
    @(posedge sys_clk);
    variant <= v;
    last_pg <= lp;
    pc <= p;
    table_ptr <= 8'h06;
    operand_addr <= 8'h41;
    tab_rd <= 1'b1;
    @(posedge sys_clk);
    #1 chk("stall", 16'h1, {15'h0, core_stall});
    @(posedge sys_clk);
    tab_rd <= 1'b0;
    #1 chk("dm_we", 16'h1, {15'h0, dm_we});
    chk("stall_end", 16'h0, {15'h0, core_stall});
    chk("dm_addr", 16'h41, {8'h0, dm_addr});
    chk("low", lo, {8'h0, dm_wdata});
    chk("high", hi, {8'h0, table_high_byte});
    repeat (2) @(posedge sys_clk);
    #1 chk("refused", 16'h0, {15'h0, dm_we});
  endtask
  // ==========================================================
  // fetch from the reset vector, high byte left alone
  task automatic fetch0();
    @(posedge sys_clk);
    variant <= PMTR_VAR_2KX15;
    pc <= 11'h000;
    fetch_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("instr", 16'h1234, {1'b0, instr_word});
    chk("high_kept", 16'h3f, {8'h0, table_high_byte});
  endtask
  initial
  begin
    #30000;
    failures++;
    $display("[FAIL] watchdog exp done got hang");
    wrap_up();
  end
  initial
  begin
    sys_clk = 0; resetn = 1; emul = 0; fetch_en = 0; tab_rd = 0; last_pg = 0;
    variant = PMTR_VAR_2KX15; pc = 0; table_ptr = 0; operand_addr = 0;
    #1 resetn = 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1 chk("fetch_addr", 16'h0, {5'h0, fetch_addr});
    chk("alt_on", 16'h1, {15'h0, alt_func_en});
    u_prog.send(PMTR_CMD_WRITE, 11'h306, 15'h7f1a);
    u_prog.send(PMTR_CMD_WRITE, 11'h706, 15'h5a3c);
    @(posedge sys_clk);
    emul <= 1'b1;
    u_prog.send(PMTR_CMD_WRITE, 11'h000, 15'h1234);
    chk("alt_off", 16'h0, {15'h0, alt_func_en});
    repeat (10) @(posedge sys_clk);
    tread(PMTR_VAR_2KX15, 1'b0, 11'h300, 16'h1a, 16'h7f);
    tread(PMTR_VAR_2KX14, 1'b0, 11'h300, 16'h1a, 16'h3f);
    tread(PMTR_VAR_2KX15, 1'b1, 11'h000, 16'h3c, 16'h5a);
    tread(PMTR_VAR_2KX14, 1'b1, 11'h000, 16'h3c, 16'h1a);
    tread(PMTR_VAR_1KX14, 1'b1, 11'h000, 16'h1a, 16'h3f);
    fetch0();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== src/pmtr_pkg.sv
// package for the program memory table read unit
// assumes a core that issues table reads and fetches on sys_clk
`default_nettype none
package pmtr_pkg;
  // ===========================================================
  // store geometry
  localparam int        PMTR_ADDR_W      = 11;
  localparam int        PMTR_WORD_W      = 15;
  localparam int        PMTR_DEPTH       = 2048;
  localparam int        PMTR_PAGE_W      = 8;
  localparam int        PMTR_HIGH_W      = PMTR_WORD_W - 8;
  localparam logic [1:0] PMTR_VAR_1KX14  = 2'h0;
  localparam logic [1:0] PMTR_VAR_2KX14  = 2'h1;
  localparam logic [1:0] PMTR_VAR_2KX15  = 2'h2;
  // ===========================================================
  // reset values
  localparam logic [PMTR_ADDR_W-1:0] PMTR_RESET_VECTOR = 11'h000;
  localparam logic [7:0]             PMTR_HIGH_RESET   = 8'h00;
  // ===========================================================
  // serial programming commands (link side)
  localparam int         PMTR_CMD_W    = 2;
  localparam logic [1:0] PMTR_CMD_WRITE = 2'h1;
  localparam logic [1:0] PMTR_CMD_READ  = 2'h2;
  localparam int         PMTR_FRAME_W  = PMTR_CMD_W + PMTR_ADDR_W + PMTR_WORD_W;
  typedef enum logic [1:0] {PMTR_IDLE, PMTR_TAB2} pmtr_state_t;
endpackage
`default_nettype wire

// ===== src/pmtr_top.sv
// program memory with fetch port, table read path and serial programming link
// assumes core holds table read request one cycle; link clock driven externally
`default_nettype none
module pmtr_top
  import pmtr_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic [1:0]             variant,
  input  wire logic                   emulation_chip,
  input  wire logic                   fetch_en,
  input  wire logic [PMTR_ADDR_W-1:0] pc,
  output var  logic [PMTR_ADDR_W-1:0] fetch_addr,
  output var  logic [PMTR_WORD_W-1:0] instr_word,
  input  wire logic                   tab_rd,
  input  wire logic                   last_page_table_read,
  input  wire logic [7:0]             table_ptr,
  input  wire logic [7:0]             operand_addr,
  output var  logic                   dm_we,
  output var  logic [7:0]             dm_addr,
  output var  logic [7:0]             dm_wdata,
  output var  logic [7:0]             table_high_byte,
  output var  logic                   core_stall,
  output var  logic                   alt_func_en,
  input  wire logic                   prog_serial_clock_pin,
  input  wire logic                   prog_serial_data_pin_i,
  output var  logic                   prog_serial_data_pin_o,
  output var  logic                   prog_serial_data_pin_oe,
  input  wire logic                   debug_clock_pin,
  input  wire logic                   debug_data_addr_pin_i,
  output var  logic                   debug_data_addr_pin_o,
  output var  logic                   debug_data_addr_pin_oe
);
  import pmtr_pkg::*;

  logic [PMTR_WORD_W-1:0] mem [PMTR_DEPTH];
  pmtr_state_t            state;
  logic [PMTR_ADDR_W-1:0] tab_addr;
  logic [PMTR_ADDR_W-1:0] addr_mask;
  logic [PMTR_WORD_W-1:0] word_mask;
  logic [PMTR_ADDR_W-1:0] last_page;
  logic [7:0]             hold_dst;
  logic [7:0]             tab_low;

  // low byte of the addressed table word, watched by the checks
  assign tab_low = mem[tab_addr][7:0];

  // ===========================================================
  // variant geometry
  always_comb
  begin
    addr_mask = (variant == PMTR_VAR_1KX14) ? 11'h3ff : 11'h7ff;
    word_mask = (variant == PMTR_VAR_2KX15) ? 15'h7fff : 15'h3fff;
    last_page = addr_mask & 11'h700;
    if (last_page_table_read)
      tab_addr = last_page | {3'h0, table_ptr};
    else
      tab_addr = (pc & 11'h700) | {3'h0, table_ptr};
    tab_addr = tab_addr & addr_mask;
  end

  // ===========================================================
  // link side: serial programming (shared with debug pins)
  logic                    lk_clk_sel;
  logic [PMTR_FRAME_W-1:0] lk_shift;
  logic [4:0]              lk_cnt;
  logic [PMTR_WORD_W-1:0]  lk_rd;
  logic                    lk_wr_tgl;
  logic                    lk_data;
  // data pins shared: debug data pin on emulation chip, programming data pin otherwise; clock always from prog_serial_clock_pin
  assign lk_data = emulation_chip ? debug_data_addr_pin_i : prog_serial_data_pin_i;

  // link clock from programmer drives shifter
  // link clock stops between frames, so reset reaches it asynchronously
  always_ff @(posedge prog_serial_clock_pin or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_cnt    <= 5'h00;
      lk_shift  <= '0;
      lk_wr_tgl <= 1'b0;
    end
    else if (lk_cnt == 5'(PMTR_FRAME_W))
    begin
      // commit edge: no shift, frame stands still for the crossing
      lk_cnt   <= 5'h00;
      if (lk_shift[PMTR_FRAME_W-1 -: PMTR_CMD_W] == PMTR_CMD_WRITE)
        lk_wr_tgl <= ~lk_wr_tgl;
    end
    else
    begin
      lk_cnt   <= lk_cnt + 5'h01;
      lk_shift <= {lk_shift[PMTR_FRAME_W-2:0], lk_data};
    end
  end

  // ===========================================================
  // crossing: frame sampled every cycle, written on toggle; stable until next frame's first link edge
  logic [2:0]              wr_sync;
  logic [PMTR_FRAME_W-1:0] frame_q;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      wr_sync <= 3'h0;
    else
      wr_sync <= {wr_sync[1:0], lk_wr_tgl};
  end

  always_ff @(posedge sys_clk)
  begin
    frame_q <= lk_shift;
    if (wr_sync[2] != wr_sync[1])
      mem[frame_q[PMTR_WORD_W +: PMTR_ADDR_W]] <= frame_q[PMTR_WORD_W-1:0] & word_mask;
  end

  // read data returned on link clock's falling edge
  // pins released until a whole read frame has been taken
  always_ff @(negedge prog_serial_clock_pin or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_rd                   <= '0;
      prog_serial_data_pin_o  <= 1'b0;
      prog_serial_data_pin_oe <= 1'b0;
      debug_data_addr_pin_o   <= 1'b0;
      debug_data_addr_pin_oe  <= 1'b0;
    end
    else
    begin
      lk_rd <= mem[lk_shift[PMTR_WORD_W-1 -: PMTR_ADDR_W]];
      prog_serial_data_pin_o  <= lk_rd[lk_cnt[3:0]];
      prog_serial_data_pin_oe <= (lk_cnt == 5'h00) && !emulation_chip
                                 && (lk_shift[PMTR_FRAME_W-1 -: PMTR_CMD_W] == PMTR_CMD_READ);
      debug_data_addr_pin_o   <= lk_rd[lk_cnt[3:0]];
      debug_data_addr_pin_oe  <= (lk_cnt == 5'h00) && emulation_chip
                                 && (lk_shift[PMTR_FRAME_W-1 -: PMTR_CMD_W] == PMTR_CMD_READ);
    end
  end

  // ===========================================================
  // fetch path
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      fetch_addr <= PMTR_RESET_VECTOR;
      instr_word <= '0;
    end
    else if (fetch_en && state == PMTR_IDLE)
    begin
      fetch_addr <= pc & addr_mask;
      instr_word <= mem[pc & addr_mask] & word_mask;
    end
  end

  // ===========================================================
  // table read: two cycles, result written in second
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state           <= PMTR_IDLE;
      dm_we           <= 1'b0;
      dm_addr         <= 8'h00;
      dm_wdata        <= 8'h00;
      hold_dst        <= 8'h00;
      table_high_byte <= PMTR_HIGH_RESET;
      core_stall      <= 1'b0;
      alt_func_en     <= 1'b1;
    end
    else
    begin
      alt_func_en <= !emulation_chip;
      dm_we       <= 1'b0;
      case (state)
        PMTR_IDLE:
          if (tab_rd)
          begin
            state      <= PMTR_TAB2;
            core_stall <= 1'b1;
            hold_dst   <= operand_addr;
            dm_wdata   <= mem[tab_addr][7:0];
            table_high_byte <= 8'((mem[tab_addr] & word_mask) >> 8);
          end
        PMTR_TAB2:
        begin
          state      <= PMTR_IDLE;
          core_stall <= 1'b0;
          dm_we      <= 1'b1;
          dm_addr    <= hold_dst;
        end
        default: state <= PMTR_IDLE;
      endcase
    end
  end

  // ===========================================================
  // checks
  a_reset_vector: assert property (@(posedge sys_clk) !resetn |=> fetch_addr == 11'h000)
    else $error("fetch not at zero after reset");
  a_tab_two_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_IDLE && tab_rd) |=> core_stall ##1 (dm_we && !core_stall))
    else $error("table read not two cycles");
  a_high_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    table_high_byte[7] == 1'b0)
    else $error("unused high bit set");
  a_high_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(state == PMTR_IDLE && tab_rd) |=> $stable(table_high_byte))
    else $error("table high changed without read");
  a_tab_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_IDLE && tab_rd) |=> dm_wdata == $past(tab_low))
    else $error("low byte wrong");
  a_dest_reg: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_IDLE && tab_rd) |-> ##2 dm_addr == $past(operand_addr, 2))
    else $error("wrong destination");
  a_page_off: assert property (@(posedge sys_clk)
    (!last_page_table_read) |-> tab_addr[7:0] == table_ptr)
    else $error("page offset wrong");
  a_last_page: assert property (@(posedge sys_clk)
    last_page_table_read |-> tab_addr[10:8] == last_page[10:8])
    else $error("last page wrong");
  a_alt_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    emulation_chip [*2] |-> !alt_func_en)
    else $error("alternate function on emulation chip");
  a_addr_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
    (variant == PMTR_VAR_1KX14) [*2] |-> fetch_addr[10] == 1'b0)
    else $error("address beyond 1K");

  a_stall_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    core_stall |=> !core_stall)
    else $error("stall longer than one cycle");

  a_we_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    dm_we |=> !dm_we)
    else $error("write strobe longer than one cycle");

  a_we_after: assert property (@(posedge sys_clk) disable iff (!resetn)
    dm_we |-> $past(core_stall))
    else $error("write strobe without stall");

  a_tab_return: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_TAB2) |=> (state == PMTR_IDLE))
    else $error("second table cycle not last");

  a_stall_state: assert property (@(posedge sys_clk) disable iff (!resetn)
    core_stall |-> (state == PMTR_TAB2))
    else $error("stall outside second cycle");

  a_fetch_stall: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_TAB2) |=> $stable(fetch_addr))
    else $error("fetch taken during stall");

  a_fetch_pc: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fetch_en && state == PMTR_IDLE) |=> fetch_addr == ($past(pc) & $past(addr_mask)))
    else $error("fetch not from program counter");

  a_fetch_narrow: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fetch_en && state == PMTR_IDLE && variant == PMTR_VAR_1KX14) |=> !fetch_addr[10])
    else $error("fetch beyond small store");

  a_instr_narrow: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fetch_en && state == PMTR_IDLE && variant != PMTR_VAR_2KX15) |=> !instr_word[14])
    else $error("instruction wider than store");

  a_high_narrow: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == PMTR_IDLE && tab_rd && variant != PMTR_VAR_2KX15) |=> !table_high_byte[6])
    else $error("unused high bit set on narrow store");

  a_dest_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    dm_we |-> dm_addr == $past(hold_dst))
    else $error("write to wrong register");

  a_reset_quiet: assert property (@(posedge sys_clk)
    !resetn |=> (!dm_we && !core_stall))
    else $error("table path busy after reset");

  a_alt_on: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!emulation_chip) [*2] |-> alt_func_en)
    else $error("alternate function off on plain chip");

  a_oe_single: assert property (@(posedge sys_clk)
    !(prog_serial_data_pin_oe && debug_data_addr_pin_oe))
    else $error("both link pins driven");

  a_page_cur: assert property (@(posedge sys_clk)
    (!last_page_table_read && variant != PMTR_VAR_1KX14) |-> tab_addr[10:8] == pc[10:8])
    else $error("table page not current page");

  a_last_big: assert property (@(posedge sys_clk)
    (last_page_table_read && variant != PMTR_VAR_1KX14) |-> tab_addr[10:8] == 3'h7)
    else $error("last page wrong on large store");

  a_last_small: assert property (@(posedge sys_clk)
    (last_page_table_read && variant == PMTR_VAR_1KX14) |-> tab_addr[10:8] == 3'h3)
    else $error("last page wrong on small store");
endmodule
`default_nettype wire
